// ==== rtl/rx_status_cfg.svh ====
`ifndef RX_STATUS_CFG_SVH
`define RX_STATUS_CFG_SVH

// bit positions of the receive status word
`define BIT_CHECK_ERR 1
`define BIT_DRIBBLE 2
`define BIT_PHY_ERR 3
`define BIT_ZERO_LO 4
`define BIT_ZERO_HI 5
`define BIT_LATE_COL 6
`define BIT_OVERSIZE 7
`define BIT_LAST_DESC 8
`define BIT_FIRST_DESC 9
`define BIT_MULTICAST 10
`define BIT_RUNT 11
`define TYPE_LSB 12
`define TYPE_MSB 13
`define BIT_ZERO_MID 14
`define BIT_SUMMARY 15
`define LEN_LSB 16
`define LEN_MSB 29
`define TOP_LSB 30
`define TOP_MSB 31

// frame length limits in bytes
`define LEN_W 14
`define LEN_ZERO 14'h0000
`define LEN_ONE 14'h0001
`define LEN_MAX 14'h3fff
`define RUNT_LIMIT 14'h0040
`define OVERSIZE_LIMIT 14'h0800
`define LATE_COL_BYTES 14'h0040

// register bus map
`define ADR_W 8
`define REG_CTRL 8'h00
`define REG_LAST_STATUS 8'h04
`define REG_FRAME_COUNT 8'h08
`define REG_STATE 8'h0c
`define CTRL_ENABLE 0
`define CTRL_TYPE_LSB 1
`define CTRL_TYPE_MSB 2
`define CTRL_ENABLE_RESET 1'h0
`define CTRL_TYPE_RESET 2'h0
`define CNT_W 16
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define WORD_ZERO 32'h0000_0000

`endif

// ==== rtl/rx_status_pkg.sv ====
package rx_status_pkg;
    typedef enum logic [3:0] {
        st_idle = 4'h1,
        st_frame = 4'h2,
        st_final = 4'h4,
        st_post = 4'h8
    } state_t;
    typedef logic [1:0] frame_type_t;
    typedef logic [31:0] word_t;
endpackage

// ==== rtl/frame_status_acc.sv ====
`timescale 1ns/10ps
`include "rx_status_cfg.svh"

module frame_status_acc (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic rx_sof,
    input wire logic rx_byte,
    input wire logic rx_eof,
    input wire logic rx_multicast,
    input wire logic rx_collision,
    input wire logic rx_phy_err,
    input wire logic rx_dribble,
    input wire logic rx_crc_bad,
    output logic [`LEN_W-1:0] byte_count,
    output logic multicast,
    output logic late_col,
    output logic phy_err,
    output logic dribble,
    output logic crc_bad
);
    wire count_full = (byte_count == `LEN_MAX);
    wire count_late = (byte_count >= `LATE_COL_BYTES);

    always_ff @(posedge clk_sys) begin
        if (rst || rx_sof) begin
            byte_count <= `LEN_ZERO;
            late_col <= 1'b0;
            phy_err <= 1'b0;
        end else begin
            if (rx_byte && !count_full)
                byte_count <= byte_count + `LEN_ONE;
            if (rx_collision && count_late)
                late_col <= 1'b1;
            if (rx_phy_err)
                phy_err <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            multicast <= 1'b0;
            dribble <= 1'b0;
            crc_bad <= 1'b0;
        end else if (rx_eof) begin
            multicast <= rx_multicast;
            dribble <= rx_dribble;
            crc_bad <= rx_crc_bad;
        end
    end

    late_only_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        $rose(late_col) |-> $past(byte_count) >= `LATE_COL_BYTES)
        else $error("late collision flagged before 64 bytes");
    phy_sticky_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        rx_phy_err && !rx_sof |=> phy_err)
        else $error("phy error not held");
endmodule // frame_status_acc

// ==== rtl/rx_desc_status.sv ====
`timescale 1ns/10ps
`include "rx_status_cfg.svh"

module rx_desc_status (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_sof,
    input wire logic rx_byte,
    input wire logic rx_eof,
    input wire logic rx_multicast,
    input wire logic rx_collision,
    input wire logic rx_phy_err,
    input wire logic rx_dribble,
    input wire logic rx_crc_bad,
    input wire logic desc_full,
    input wire logic status_ready,
    output rx_status_pkg::word_t status_word,
    output logic status_valid,
    output logic frame_good
);
    rx_status_pkg::state_t state;
    rx_status_pkg::state_t next_state;
    rx_status_pkg::frame_type_t ctrl_type;
    logic ctrl_enable;
    logic first_pend;
    logic eof_pend;
    logic ret_frame;
    logic [`CNT_W-1:0] frame_count;
    logic [`LEN_W-1:0] acc_len;
    logic acc_multicast;
    logic acc_late;
    logic acc_phy;
    logic acc_dribble;
    logic acc_crc;

    frame_status_acc u_acc (
        .clk_sys(clk_sys),
        .rst(rst),
        .rx_sof(rx_sof),
        .rx_byte(rx_byte),
        .rx_eof(rx_eof),
        .rx_multicast(rx_multicast),
        .rx_collision(rx_collision),
        .rx_phy_err(rx_phy_err),
        .rx_dribble(rx_dribble),
        .rx_crc_bad(rx_crc_bad),
        .byte_count(acc_len),
        .multicast(acc_multicast),
        .late_col(acc_late),
        .phy_err(acc_phy),
        .dribble(acc_dribble),
        .crc_bad(acc_crc)
    );

    // derived per-frame conditions
    // short frame
    wire is_runt = (acc_len < `RUNT_LIMIT);
    wire is_oversize = (acc_len > `OVERSIZE_LIMIT);
    wire check_err = acc_crc | acc_phy;
    wire dribble_eff = acc_dribble & ~acc_late & ~is_runt;
    wire summary = check_err | acc_late | is_oversize | is_runt;
    wire good_now = ~check_err & ~acc_late & ~is_oversize & ~is_runt;

    // builds one status word; per-frame fields only when full is set
    function automatic rx_status_pkg::word_t compose(
        input logic fd,
        input logic ld,
        input logic full
    );
        rx_status_pkg::word_t w;
        w = `WORD_ZERO;
        w[`BIT_FIRST_DESC] = fd;
        w[`BIT_LAST_DESC] = ld;
        // flags only in a final word
        if (full) begin
            w[`LEN_MSB:`LEN_LSB] = acc_len;
            w[`BIT_SUMMARY] = summary;
            w[`TYPE_MSB:`TYPE_LSB] = ctrl_type;
            w[`BIT_RUNT] = is_runt;
            w[`BIT_MULTICAST] = acc_multicast;
            w[`BIT_OVERSIZE] = is_oversize;
            w[`BIT_LATE_COL] = acc_late;
            w[`BIT_PHY_ERR] = acc_phy;
            w[`BIT_DRIBBLE] = dribble_eff;
            w[`BIT_CHECK_ERR] = check_err;
        end
        return w;
    endfunction

    // writeback events
    // middle descriptor closes
    wire emit_mid = (state == rx_status_pkg::st_frame) & ~rx_eof & desc_full;
    wire emit_fin = (state == rx_status_pkg::st_final);
    wire emit = emit_mid | emit_fin;
    wire [31:0] next_word = emit_fin ? compose(first_pend, 1'b1, 1'b1)
                                     : compose(first_pend, 1'b0, 1'b0);
    wire post_done = (state == rx_status_pkg::st_post) & status_ready;
    wire frame_start = (state == rx_status_pkg::st_idle) & rx_sof
                       & ctrl_enable;

    always_comb begin
        next_state = state;
        unique case (state)
            rx_status_pkg::st_idle: begin
                if (frame_start)
                    next_state = rx_status_pkg::st_frame;
            end
            rx_status_pkg::st_frame: begin
                if (rx_eof)
                    next_state = rx_status_pkg::st_final;
                else if (desc_full)
                    next_state = rx_status_pkg::st_post;
            end
            rx_status_pkg::st_final: begin
                next_state = rx_status_pkg::st_post;
            end
            rx_status_pkg::st_post: begin
                if (status_ready && ret_frame && (eof_pend || rx_eof))
                    next_state = rx_status_pkg::st_final;
                else if (status_ready && ret_frame)
                    next_state = rx_status_pkg::st_frame;
                else if (status_ready)
                    next_state = rx_status_pkg::st_idle;
            end
            default: begin
                next_state = rx_status_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            state <= rx_status_pkg::st_idle;
        else
            state <= next_state;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            first_pend <= 1'b0;
            ret_frame <= 1'b0;
            eof_pend <= 1'b0;
        end else begin
            if (frame_start)
                first_pend <= 1'b1;
            else if (emit)
                first_pend <= 1'b0;
            if (emit)
                ret_frame <= emit_mid;
            // frame end seen while a middle word still waits for the host
            if ((state == rx_status_pkg::st_post) && rx_eof && !status_ready)
                eof_pend <= 1'b1;
            else if (post_done)
                eof_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_word <= `WORD_ZERO;
            status_valid <= 1'b0;
        end else if (emit) begin
            status_word <= next_word;
            status_valid <= 1'b1;
        end else if (post_done) begin
            status_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            frame_count <= `CNT_ZERO;
            frame_good <= 1'b0;
        end else if (emit_fin) begin
            frame_count <= frame_count + `CNT_ONE;
            frame_good <= good_now;
        end
    end

    // register bus slave
    wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire ctrl_wr = wb_hit & wb_we_i & wb_sel_i[0]
                   & (wb_adr_i == `REG_CTRL);
    wire busy = (state != rx_status_pkg::st_idle);
    wire [31:0] ctrl_rd = {29'h0000_0000, ctrl_type, ctrl_enable};
    wire [31:0] count_rd = {16'h0000, frame_count};
    wire [31:0] state_rd = {29'h0000_0000, frame_good, status_valid, busy};
    wire [31:0] rd_mux =
        (wb_adr_i == `REG_CTRL) ? ctrl_rd :
        (wb_adr_i == `REG_LAST_STATUS) ? status_word :
        (wb_adr_i == `REG_FRAME_COUNT) ? count_rd :
        (wb_adr_i == `REG_STATE) ? state_rd : `WORD_ZERO;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `WORD_ZERO;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i)
                wb_dat_o <= rd_mux;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_enable <= `CTRL_ENABLE_RESET;
            ctrl_type <= `CTRL_TYPE_RESET;
        end else if (ctrl_wr) begin
            ctrl_enable <= wb_dat_i[`CTRL_ENABLE];
            ctrl_type <= wb_dat_i[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB];
        end
    end

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // checker helper: high until the host takes a frame's first word
    logic first_due;
    always_ff @(posedge clk_sys) begin
        if (rst)
            first_due <= 1'b0;
        else if (frame_start)
            first_due <= 1'b1;
        else if (post_done)
            first_due <= 1'b0;
    end

    zero_bits_a: assert property (
        status_valid |-> status_word[`TOP_MSB:`TOP_LSB] == 2'h0
            && !status_word[`BIT_ZERO_MID]
            && status_word[`BIT_ZERO_HI:`BIT_ZERO_LO] == 2'h0)
        else $error("unassigned status bit set");

    mid_flags_a: assert property (
        status_valid && !status_word[`BIT_LAST_DESC]
            |-> status_word[`LEN_MSB:`BIT_MULTICAST] == 20'h0_0000
            && status_word[`BIT_OVERSIZE:`BIT_CHECK_ERR] == 7'h00)
        else $error("per-frame flag in non-final word");

    summary_a: assert property (
        status_valid && status_word[`BIT_LAST_DESC]
            |-> status_word[`BIT_SUMMARY] == (status_word[`BIT_CHECK_ERR]
            | status_word[`BIT_LATE_COL] | status_word[`BIT_OVERSIZE]
            | status_word[`BIT_RUNT]))
        else $error("error summary mismatch");

    phy_crc_a: assert property (
        status_valid && status_word[`BIT_PHY_ERR]
            |-> status_word[`BIT_CHECK_ERR])
        else $error("phy error without check error");

    dribble_mask_a: assert property (
        status_valid && (status_word[`BIT_LATE_COL]
            || status_word[`BIT_RUNT]) |-> !status_word[`BIT_DRIBBLE])
        else $error("dribble reported with late or runt");

    runt_len_a: assert property (
        status_valid && status_word[`BIT_LAST_DESC]
            |-> status_word[`BIT_RUNT]
            == (status_word[`LEN_MSB:`LEN_LSB] < `RUNT_LIMIT))
        else $error("runt flag disagrees with length");

    oversize_len_a: assert property (
        status_valid && status_word[`BIT_LAST_DESC]
            |-> status_word[`BIT_OVERSIZE]
            == (status_word[`LEN_MSB:`LEN_LSB] > `OVERSIZE_LIMIT))
        else $error("oversize flag disagrees with length");

    final_after_eof_a: assert property (
        state == rx_status_pkg::st_frame && rx_eof
            |-> ##2 status_valid && status_word[`BIT_LAST_DESC])
        else $error("final word not posted two cycles after frame end");

    first_marker_a: assert property (
        status_valid |-> status_word[`BIT_FIRST_DESC] == first_due)
        else $error("first marker on wrong descriptor");

    word_hold_a: assert property (
        status_valid && !status_ready |=> status_valid
            && $stable(status_word))
        else $error("status word changed before taken");

    type_copy_a: assert property (
        emit_fin |=> status_word[`TYPE_MSB:`TYPE_LSB] == $past(ctrl_type))
        else $error("frame type not copied");

    single_desc_a: assert property (
        state == rx_status_pkg::st_frame && rx_eof && first_due
            |-> ##2 status_word[`BIT_FIRST_DESC]
            && status_word[`BIT_LAST_DESC])
        else $error("single descriptor frame lacks both markers");
endmodule // rx_desc_status

// ==== tb/status_host.sv ====
`timescale 1ns/10ps

module status_host (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic status_valid,
    input wire rx_status_pkg::word_t status_word,
    input wire logic [3:0] delay,
    output logic status_ready,
    output logic [7:0] count,
    output rx_status_pkg::word_t words [0:7]
);
    logic [3:0] wait_cnt;

    assign status_ready = status_valid && (wait_cnt >= delay);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_cnt <= 4'h0;
            count <= 8'h00;
        end else if (status_ready) begin
            wait_cnt <= 4'h0;
            count <= count + 8'h01;
            words[count[2:0]] <= status_word;
        end else if (status_valid) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // status_host

// ==== tb/tb_rx_desc_status.sv ====
`timescale 1ns/10ps

module tb_rx_desc_status;
    typedef struct {
        logic [13:0] len;
        logic mc;
        logic [13:0] col;
        logic phy, drib, crc;
        logic [13:0] df1, df2;
        logic [3:0] dly;
        logic good;
    } row_t;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, status_ready, status_valid, frame_good;
    logic rx_sof = 1'h0, rx_byte = 1'h0, rx_eof = 1'h0, desc_full = 1'h0;
    logic rx_multicast = 1'h0, rx_collision = 1'h0, rx_phy_err = 1'h0;
    logic rx_dribble = 1'h0, rx_crc_bad = 1'h0;
    logic [3:0] host_delay = 4'h0;
    logic [7:0] count, base;
    rx_status_pkg::word_t status_word, last_exp;
    rx_status_pkg::word_t words [0:7];
    row_t rows [0:10];
    int n_mismatch = 0, check_count = 0, cycles = 0, t;

    rx_desc_status u_dut (.clk_sys(clk_sys), .rst(rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_sof(rx_sof),
        .rx_byte(rx_byte), .rx_eof(rx_eof), .rx_multicast(rx_multicast),
        .rx_collision(rx_collision), .rx_phy_err(rx_phy_err),
        .rx_dribble(rx_dribble), .rx_crc_bad(rx_crc_bad),
        .desc_full(desc_full), .status_ready(status_ready),
        .status_word(status_word), .status_valid(status_valid),
        .frame_good(frame_good));
    status_host u_host (.clk_sys(clk_sys), .rst(rst),
        .status_valid(status_valid), .status_word(status_word),
        .delay(host_delay), .status_ready(status_ready), .count(count),
        .words(words));

    always #10 clk_sys = ~clk_sys;

    task close_out;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        @(posedge clk_sys);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask

    function automatic logic [31:0] exp_last(row_t r, logic [1:0] ty,
                                             logic first);
        logic runt, over, late, err;
        runt = r.len < 14'h0040;
        over = r.len > 14'h0800;
        late = r.col >= 14'h0040;
        err = r.crc | r.phy | late | over | runt;
        exp_last = {2'h0, r.len, err, 1'h0, ty, runt, r.mc, first, 1'h1,
                    over, late, 2'h0, r.phy, r.drib & ~late & ~runt,
                    r.crc | r.phy, 1'h0};
    endfunction

    task automatic drive(row_t r);
        host_delay <= r.dly;
        rx_multicast <= r.mc;
        rx_dribble <= r.drib;
        rx_crc_bad <= r.crc;
        @(posedge clk_sys);
        rx_sof <= 1'h1;
        for (int i = 0; i < r.len; i++) begin
            @(posedge clk_sys);
            rx_sof <= 1'h0;
            rx_byte <= 1'h1;
            desc_full <= (r.df1 != 0 && i == r.df1) ||
                         (r.df2 != 0 && i == r.df2);
            rx_collision <= r.col != 0 && i == r.col;
            rx_phy_err <= r.phy && i == 5;
        end
        @(posedge clk_sys);
        {rx_byte, desc_full, rx_collision, rx_phy_err} <= 4'h0;
        rx_eof <= 1'h1;
        @(posedge clk_sys);
        rx_eof <= 1'h0;
    endtask

    task automatic run_row(row_t r, logic [1:0] ty);
        int n;
        logic [31:0] e;
        base = count;
        n = 1 + int'(r.df1 != 0) + int'(r.df2 != 0);
        drive(r);
        while (count !== 8'(base + n))
            @(posedge clk_sys);
        for (int j = 0; j < n; j++) begin
            e = (j == 0) ? 32'h0000_0200 : 32'h0;
            if (j == n - 1)
                e = exp_last(r, ty, n == 1);
            chk_word(words[3'(base + j)], e);
        end
        last_exp = e;
        repeat (3) @(posedge clk_sys);
        chk_bit(frame_good, r.good);
    endtask

    initial begin
        rows[0] = '{14'h64, 1'h1, 14'h0, 1'h0, 1'h0, 1'h0, 14'h0, 14'h0,
                    4'h0, 1'h1};
        rows[1] = '{14'h3f, 1'h0, 14'h0, 1'h0, 1'h1, 1'h0, 14'h0, 14'h0,
                    4'h2, 1'h0};
        rows[2] = '{14'h40, 1'h0, 14'h0, 1'h0, 1'h1, 1'h0, 14'h0, 14'h0,
                    4'h0, 1'h1};
        rows[3] = '{14'h800, 1'h0, 14'h0, 1'h0, 1'h0, 1'h0, 14'h0, 14'h0,
                    4'h0, 1'h1};
        rows[4] = '{14'h801, 1'h0, 14'h0, 1'h0, 1'h0, 1'h0, 14'h0, 14'h0,
                    4'h1, 1'h0};
        rows[5] = '{14'h64, 1'h0, 14'h46, 1'h0, 1'h1, 1'h0, 14'h0, 14'h0,
                    4'h0, 1'h0};
        rows[6] = '{14'h64, 1'h0, 14'h28, 1'h0, 1'h0, 1'h0, 14'h0, 14'h0,
                    4'h0, 1'h1};
        rows[7] = '{14'h64, 1'h0, 14'h0, 1'h1, 1'h0, 1'h0, 14'h0, 14'h0,
                    4'h0, 1'h0};
        rows[8] = '{14'h64, 1'h0, 14'h0, 1'h0, 1'h0, 1'h1, 14'h0, 14'h0,
                    4'h0, 1'h0};
        rows[9] = '{14'h12c, 1'h0, 14'h0, 1'h0, 1'h0, 1'h0, 14'h64, 14'hc8,
                    4'h3, 1'h1};
        rows[10] = '{14'h82, 1'h1, 14'h0, 1'h0, 1'h1, 1'h1, 14'h81, 14'h0,
                     4'h8, 1'h0};
        repeat (11) @(posedge clk_sys);
        chk_bit(status_valid, 1'h0);
        chk_word(status_word, 32'h0);
        chk_bit(frame_good, 1'h0);
        @(posedge clk_sys);
        rst <= 1'h0;
        $display("test reset done");
        wb(1'h1, 8'h00, 32'h0000_0003);
        for (int i = 0; i < 11; i++)
            run_row(rows[i], 2'h1);
        $display("test rows done");
        for (t = 0; t < 4; t++) begin
            wb(1'h1, 8'h00, {29'h0, 2'(t), 1'h1});
            run_row(rows[0], 2'(t));
        end
        wb(1'h0, 8'h04, 32'h0);
        chk_word(rd, last_exp);
        $display("test frame types done");
        wb(1'h0, 8'h08, 32'h0);
        chk_word(rd, 32'h0000_000f);
        wb(1'h1, 8'h40, 32'hffff_ffff);
        wb(1'h0, 8'h40, 32'h0);
        chk_word(rd, 32'h0);
        wb_sel_i <= 4'he;
        wb(1'h1, 8'h00, 32'h0);
        wb_sel_i <= 4'hf;
        wb(1'h0, 8'h00, 32'h0);
        chk_word(rd, 32'h0000_0007);
        wb(1'h0, 8'h0c, 32'h0);
        chk_word(rd, 32'h0000_0004);
        wb(1'h1, 8'h00, 32'h0);
        base = count;
        drive(rows[0]);
        repeat (20) @(posedge clk_sys);
        chk_word({24'h0, count}, {24'h0, base});
        chk_bit(status_valid, 1'h0);
        $display("test registers done");
        wb(1'h1, 8'h00, 32'h0000_0003);
        drive(rows[10]);
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        chk_bit(status_valid, 1'h0);
        chk_word(status_word, 32'h0);
        chk_bit(frame_good, 1'h0);
        chk_bit(wb_ack_o, 1'h0);
        chk_word(wb_dat_o, 32'h0);
        rst <= 1'h0;
        wb(1'h0, 8'h00, 32'h0);
        chk_word(rd, 32'h0);
        wb(1'h0, 8'h08, 32'h0);
        chk_word(rd, 32'h0);
        wb(1'h1, 8'h00, 32'h0000_0003);
        run_row(rows[0], 2'h1);
        $display("test mid reset done");
        close_out();
    end
endmodule // tb_rx_desc_status
